// ==== design/fpimg_pkg.sv ====
// Notes on behaviour
// - Control word at bytes 00h-01h, status word at 02h-03h.
// - Abridged tag byte at 04h; byte 05h always written as zero.
// - Last floating-point opcode stored at bytes 06h-07h.
// - Instruction pointer: 64-bit offset at 08h, or 32-bit offset plus selector.
// - Data pointer: 64-bit offset at 10h, or 32-bit offset plus selector.
// - Data pointer words written as zero when last instruction touched no memory.
// - Media control word at 18h saved only while media-save enable is one.
// - Capability mask at 1Ch; set bits supported, clear bits reserved, except that a zero mask allows MCS_DEFAULT_MASK.
// - Writing one into a reserved media control bit raises a protection fault.
// - Mask bit 6 set only with denormals-as-zero; zero mask means unsupported.
// - Eight stack registers in stack-top order, 16-byte slots from 20h.
// - Media registers from A0h, to 11Fh outside 64-bit mode, if enabled.
// - Two-bit tags 00, 01 and 10 compress to a one.
// - Two-bit tag 11 compresses to a zero.
// - Compressed tag bit i belongs to physical register i.
package fpimg_pkg;
  // Image byte offsets
  localparam logic [11:0] OFF_FCW     = 12'h000;
  localparam logic [11:0] OFF_TAG     = 12'h004;
  localparam logic [11:0] OFF_INSTR   = 12'h008;
  localparam logic [11:0] OFF_INSTR_H = 12'h00c;
  localparam logic [11:0] OFF_DATA    = 12'h010;
  localparam logic [11:0] OFF_DATA_H  = 12'h014;
  localparam logic [11:0] OFF_MCS     = 12'h018;
  localparam logic [11:0] OFF_MASK    = 12'h01c;
  localparam logic [11:0] OFF_STACK   = 12'h020;
  localparam logic [11:0] OFF_MEDIA   = 12'h0a0;
  localparam logic [11:0] OFF_END32   = 12'h120;
  localparam logic [11:0] OFF_END64   = 12'h1a0;
  // Control registers behind the image window
  localparam logic [11:0] REG_CTRL    = 12'h200;
  localparam logic [11:0] REG_CMD     = 12'h204;
  localparam logic [11:0] REG_STATUS  = 12'h208;
  localparam int          IMG_WORDS   = 128;
  localparam int          DAZ_BIT     = 6;
  localparam logic [31:0] MCS_DEFAULT_MASK = 32'h0000_ffbf;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;

  typedef enum logic [1:0] {
    FPIMG_IDLE  = 2'b00,
    FPIMG_STORE = 2'b01,
    FPIMG_LOAD  = 2'b10
  } fpimg_phase_type;

  typedef struct packed {
    logic [15:0]             fp_control_word;
    logic [15:0]             fp_status_word;
    logic [15:0]             tag;
    logic [15:0]             opcode;
    logic [63:0]             instr_off;
    logic [15:0]             code_sel;
    logic [63:0]             data_off;
    logic [15:0]             data_sel;
    logic [31:0]             mcs;
    logic [7:0][79:0]        st;
    logic [15:0][127:0]      media;
  } fpimg_state_type;
endpackage : fpimg_pkg

// ==== design/fpimg_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpimg_formatter
  import fpimg_pkg::*;
#(
  parameter bit          DAZ_SUPPORTED = 1'b1,
  parameter logic [31:0] SUPPORTED_MCS = 32'h0000_ffff
) (
  input  wire logic            pclk,           // Core clock
  input  wire logic            presetn,        // Async reset, low
  input  wire logic            psel,           // APB select
  input  wire logic            penable,        // APB enable
  input  wire logic            pwrite,         // APB direction
  input  wire logic [11:0]     paddr,          // APB byte address
  input  wire logic [31:0]     pwdata,         // APB write data
  output logic                 pready,         // APB ready
  output logic [31:0]          prdata,         // APB read data
  output logic                 pslverr,        // APB error
  input  wire fpimg_state_type cur_state,      // Live register state
  input  wire logic            data_ptr_valid, // Last op touched memory
  output fpimg_state_type      restored,       // State rebuilt by load
  output logic                 load_done,      // Load finished pulse
  output logic                 gp_fault,       // Protection fault pulse
  output logic                 busy            // Store or load running
);

  localparam logic [6:0] W_FCW     = OFF_FCW[8:2];
  localparam logic [6:0] W_TAG     = OFF_TAG[8:2];
  localparam logic [6:0] W_INSTR   = OFF_INSTR[8:2];
  localparam logic [6:0] W_INSTR_H = OFF_INSTR_H[8:2];
  localparam logic [6:0] W_DATA    = OFF_DATA[8:2];
  localparam logic [6:0] W_DATA_H  = OFF_DATA_H[8:2];
  localparam logic [6:0] W_MCS     = OFF_MCS[8:2];
  localparam logic [6:0] W_MASK    = OFF_MASK[8:2];
  localparam logic [6:0] W_STACK   = OFF_STACK[8:2];
  localparam logic [6:0] W_MEDIA   = OFF_MEDIA[8:2];
  localparam logic [6:0] W_END32   = OFF_END32[8:2];
  localparam logic [6:0] W_END64   = OFF_END64[8:2];

  // Zero mask advertises no denormals-as-zero support
  localparam logic [31:0] CAP_MASK = DAZ_SUPPORTED ? SUPPORTED_MCS : 32'h0000_0000;
  localparam logic [31:0] ALLOWED  = (CAP_MASK == 32'h0) ? MCS_DEFAULT_MASK : CAP_MASK;

  if (SUPPORTED_MCS[31:16] != 16'h0 || (DAZ_SUPPORTED && !SUPPORTED_MCS[DAZ_BIT]))
    $error("fpimg_formatter: SUPPORTED_MCS cannot be served");

  ////////////////////////////////////////////////////////////////////////////////
  // Tag helpers
  function automatic logic [7:0] compress_tag(input logic [15:0] t);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c[i] = ~(t[2*i] & t[2*i+1]);
    end
    return c;
  endfunction : compress_tag

  // Full maps to valid, empty to empty; finer classes left to software
  function automatic logic [15:0] expand_tag(input logic [7:0] c);
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      t[2*i+:2] = c[i] ? 2'b00 : 2'b11;
    end
    return t;
  endfunction : expand_tag

  // One image word with its write enable
  function automatic logic [32:0] image_word(input logic [6:0] w, input fpimg_state_type s,
                                             input logic m64, input logic osen,
                                             input logic dpv);
    logic [6:0]  k;
    logic [31:0] d;
    logic        we;
    logic [79:0] sv;
    k  = 7'h00;
    d  = 32'h0;
    we = 1'b1;
    sv = 80'h0;
    if (w == W_FCW) begin
      d = {s.fp_status_word, s.fp_control_word};
    end else if (w == W_TAG) begin
      d = {s.opcode, 8'h00, compress_tag(s.tag)};
    end else if (w == W_INSTR) begin
      d = s.instr_off[31:0];
    end else if (w == W_INSTR_H) begin
      d = m64 ? s.instr_off[63:32] : {16'h0000, s.code_sel};
    end else if (w == W_DATA) begin
      d = dpv ? s.data_off[31:0] : 32'h0;
    end else if (w == W_DATA_H) begin
      d = !dpv ? 32'h0 : m64 ? s.data_off[63:32] : {16'h0000, s.data_sel};
    end else if (w == W_MCS) begin
      we = osen;
      d  = s.mcs;
    end else if (w == W_MASK) begin
      d = CAP_MASK;
    end else if (w < W_MEDIA) begin
      k  = w - W_STACK;
      sv = s.st[k[4:2]];
      case (k[1:0])
        2'd0:    d = sv[31:0];
        2'd1:    d = sv[63:32];
        2'd2:    d = {16'h0000, sv[79:64]};
        default: d = 32'h0;
      endcase
    end else begin
      k  = w - W_MEDIA;
      we = osen && (m64 ? (w < W_END64) : (w < W_END32));
      d  = s.media[k[5:2]][{k[1:0], 5'd0}+:32];
    end
    return {we, d};
  endfunction : image_word

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [31:0]     img [IMG_WORDS];
  fpimg_phase_type phase, next_phase;
  logic [6:0]      idx, next_idx;
  logic [1:0]      ctrl, next_ctrl;         // [0] 64-bit format, [1] media-save enable
  logic            gpf_sticky, next_gpf_sticky;
  logic            next_load_done, next_gp_fault;
  fpimg_state_type next_restored;
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  logic            mode_64, os_media_save_enable;
  logic            setup, access, img_sel, is_ctrl, is_cmd, is_stat, mapped;
  logic            do_write, cmd_store, cmd_load, mcs_bad;
  logic [6:0]      last_word;
  logic [32:0]     eng;
  logic            mem_we;
  logic [6:0]      mem_idx;
  logic [31:0]     mem_data, rd_word;

  assign mode_64              = ctrl[0];
  assign os_media_save_enable = ctrl[1];
  assign busy                 = (phase != FPIMG_IDLE);
  assign pready               = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode; read data and error are captured in the setup cycle
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign img_sel  = (paddr[11:9] == 3'b000);
  assign is_ctrl  = (paddr[11:2] == REG_CTRL[11:2]);
  assign is_cmd   = (paddr[11:2] == REG_CMD[11:2]);
  assign is_stat  = (paddr[11:2] == REG_STATUS[11:2]);
  assign mapped   = img_sel | is_ctrl | is_cmd | is_stat;
  assign do_write = access & pwrite & ~pslverr;
  assign rd_word  = img[paddr[8:2]];

  // Image and control writes are refused while the engine owns the image
  always_comb begin
    next_prdata  = 32'h0;
    next_pslverr = !mapped || (pwrite && busy && !is_stat);
    if (!pwrite && img_sel) begin
      next_prdata = rd_word;
    end else if (!pwrite && is_ctrl) begin
      next_prdata = {30'h0, ctrl};
    end else if (!pwrite && is_stat) begin
      next_prdata = {23'h0, idx, gpf_sticky, busy};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: one image word per cycle for store and load
  assign cmd_store = do_write & is_cmd & pwdata[0];
  assign cmd_load  = do_write & is_cmd & pwdata[1] & ~pwdata[0];
  assign mcs_bad   = os_media_save_enable && ((img[W_MCS] & ~ALLOWED) != 32'h0);
  assign last_word = !os_media_save_enable ? W_MEDIA - 7'd1 :
                     mode_64 ? W_END64 - 7'd1 : W_END32 - 7'd1;
  assign eng       = image_word(idx, cur_state, mode_64, os_media_save_enable, data_ptr_valid);

  always_comb begin
    next_phase      = phase;
    next_idx        = idx;
    next_ctrl       = ctrl;
    next_load_done  = 1'b0;
    next_gp_fault   = 1'b0;
    next_gpf_sticky = gpf_sticky;
    if (do_write && is_ctrl) begin
      next_ctrl = pwdata[1:0];
    end
    // Sticky fault: clear by writing one, a new fault wins
    if (do_write && is_stat && pwdata[1]) begin
      next_gpf_sticky = 1'b0;
    end
    case (phase)
      FPIMG_IDLE: begin
        next_idx = 7'h00;
        if (cmd_store) begin
          next_phase = FPIMG_STORE;
        end else if (cmd_load && mcs_bad) begin
          next_gp_fault   = 1'b1;
          next_gpf_sticky = 1'b1;
        end else if (cmd_load) begin
          next_phase = FPIMG_LOAD;
        end
      end
      FPIMG_STORE, FPIMG_LOAD: begin
        next_idx = idx + 7'd1;
        if (idx == last_word) begin
          next_phase     = FPIMG_IDLE;
          next_load_done = (phase == FPIMG_LOAD);
        end
      end
      default: next_phase = FPIMG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase      <= FPIMG_IDLE;
      idx        <= 7'h00;
      ctrl       <= CTRL_RESET;
      gpf_sticky <= 1'b0;
      load_done  <= 1'b0;
      gp_fault   <= 1'b0;
    end else begin
      phase      <= next_phase;
      idx        <= next_idx;
      ctrl       <= next_ctrl;
      gpf_sticky <= next_gpf_sticky;
      load_done  <= next_load_done;
      gp_fault   <= next_gp_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Image memory: engine during store, APB otherwise
  always_comb begin
    mem_we   = 1'b0;
    mem_idx  = paddr[8:2];
    mem_data = pwdata;
    if (phase == FPIMG_STORE) begin
      mem_we   = eng[32];
      mem_idx  = idx;
      mem_data = eng[31:0];
    end else if (do_write && img_sel) begin
      mem_we = 1'b1;
    end
  end

  // No reset: image contents are software data
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      img[mem_idx] <= mem_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Load: rebuild state from the same positions used by store
  always_comb begin
    logic [6:0]  k;
    logic [31:0] d;
    k             = idx - W_STACK;
    d             = img[idx];
    next_restored = restored;
    if (phase == FPIMG_LOAD) begin
      if (idx == W_FCW) begin
        next_restored.fp_control_word = d[15:0];
        next_restored.fp_status_word = d[31:16];
      end else if (idx == W_TAG) begin
        next_restored.tag    = expand_tag(d[7:0]);
        next_restored.opcode = d[31:16];
      end else if (idx == W_INSTR) begin
        next_restored.instr_off[31:0] = d;
      end else if (idx == W_INSTR_H) begin
        next_restored.instr_off[63:32] = mode_64 ? d : 32'h0;
        next_restored.code_sel         = mode_64 ? 16'h0 : d[15:0];
      end else if (idx == W_DATA) begin
        next_restored.data_off[31:0] = d;
      end else if (idx == W_DATA_H) begin
        next_restored.data_off[63:32] = mode_64 ? d : 32'h0;
        next_restored.data_sel        = mode_64 ? 16'h0 : d[15:0];
      end else if (idx == W_MCS && os_media_save_enable) begin
        next_restored.mcs = d;
      end else if (idx >= W_STACK && idx < W_MEDIA) begin
        case (k[1:0])
          2'd0:    next_restored.st[k[4:2]][31:0]  = d;
          2'd1:    next_restored.st[k[4:2]][63:32] = d;
          2'd2:    next_restored.st[k[4:2]][79:64] = d[15:0];
          default: next_restored.st[k[4:2]]        = restored.st[k[4:2]];
        endcase
      end else if (idx >= W_MEDIA) begin
        k = idx - W_MEDIA;
        next_restored.media[k[5:2]][{k[1:0], 5'd0}+:32] = d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restored <= '0;
    end else begin
      restored <= next_restored;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic st_w;
  assign st_w = (phase == FPIMG_STORE);

  sequence s_load_start;
    phase == FPIMG_IDLE ##1 phase == FPIMG_LOAD;
  endsequence
  sequence s_bad_load;
    phase == FPIMG_IDLE && cmd_load && mcs_bad;
  endsequence

  a_ctrl_words: assert property (st_w && idx == W_FCW |=>
    img[W_FCW] == {$past(cur_state.fp_status_word), $past(cur_state.fp_control_word)})
    else $error("control and status words misplaced");
  a_tag_byte: assert property (st_w && idx == W_TAG && cur_state.tag == 16'h83f1 |=>
    img[W_TAG][15:0] == 16'h00e3)
    else $error("tag byte or zero byte wrong");
  a_opcode_word: assert property (st_w && idx == W_TAG |=>
    img[W_TAG][31:8] == {$past(cur_state.opcode), 8'h00})
    else $error("opcode or reserved byte wrong");
  a_code_sel: assert property (st_w && idx == W_INSTR_H && !mode_64 |=>
    img[W_INSTR_H] == {16'h0000, $past(cur_state.code_sel)})
    else $error("code selector misplaced");
  a_data_sel: assert property (st_w && idx == W_DATA_H && !mode_64 && data_ptr_valid |=>
    img[W_DATA_H] == {16'h0000, $past(cur_state.data_sel)})
    else $error("data selector misplaced");
  a_mcs_gate: assert property (st_w && idx == W_MCS && !os_media_save_enable |=>
    $stable(img[W_MCS]))
    else $error("media control saved while disabled");
  a_mask_word: assert property (st_w && idx == W_MASK |=> img[W_MASK] == CAP_MASK)
    else $error("capability mask wrong");
  a_media_range: assert property (st_w && !mode_64 |-> !(mem_we && idx >= W_END32))
    else $error("write above media window");
  a_gp_refuse: assert property (s_bad_load |=> gp_fault && phase == FPIMG_IDLE ##1 !gp_fault)
    else $error("reserved media control bit not faulted");
  a_load_done: assert property (s_load_start |-> ##[1:110] load_done)
    else $error("load did not finish");

endmodule : fpimg_formatter
`default_nettype wire

// ==== tb/fpimg_sysmem.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// System memory copy of the image that software edits between store and load
module fpimg_sysmem
  import fpimg_pkg::*;
();
  logic [31:0] mem [IMG_WORDS];

  // Software masks the media control value of the load test before putting it back
  function automatic logic [31:0] mcs_clean(input logic [31:0] v,
                                            input logic [31:0] m);
    return (m == 32'h0) ? (v & MCS_DEFAULT_MASK) : (v & m);
  endfunction : mcs_clean
endmodule : fpimg_sysmem
`default_nettype wire

// ==== tb/fp_state_image_formatter_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fp_state_image_formatter_bench
  import fpimg_pkg::*;
;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, q;
  logic            load_done, gp_fault, busy, dpv, e, ld;
  fpimg_state_type cs, rs;
  int              n_errors, tests_run, n;

  fpimg_formatter i_fpimg_formatter (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cur_state(cs),
    .data_ptr_valid(dpv), .restored(rs), .load_done(load_done),
    .gp_fault(gp_fault), .busy(busy));
  fpimg_sysmem i_fpimg_sysmem ();

  ////////////////////////////////////////////////////////////////////////////
  // Free-running core clock, 40 ns
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // One APB transfer; an idle edge first keeps drivers from double assigning
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, x, q);
  endtask : rd

  // Issue a command and count busy cycles; bounded so a hang cannot stall
  // First look is just after the command's own access edge, where busy rises
  task automatic run(input logic [31:0] c);
    apb(1'b1, REG_CMD, c);
    n = 0; ld = 1'b0;
    for (int k = 0; k < 300; k++) begin
      #1;
      if (busy === 1'b1) n++;
      else if (n > 0) begin ld = load_done; break; end
      @(posedge pclk);
    end
  endtask : run

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs a few thousand cycles at most
  initial begin
    #(40 * 20000);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0; tests_run = 0; dpv = 1'b1; presetn = 1'b0;
    cs = '0;
    cs.fp_control_word = 16'h037f; cs.fp_status_word = 16'h1234; cs.tag = 16'h83f1; cs.opcode = 16'h07ab;
    cs.instr_off = 64'h1111_2222_3333_4444; cs.code_sel = 16'h0c0d;
    cs.data_off = 64'h5555_6666_7777_8888; cs.data_sel = 16'h1415;
    cs.mcs = 32'h0000_1f80;
    for (int i = 0; i < 8; i++) cs.st[i] = {16'hc000 + 16'(i), 64'h0123_4567_89ab_cdef};
    for (int i = 0; i < 16; i++) cs.media[i] = {4{32'hd000_0000 + 32'(i)}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Store, 32-bit format, media enabled
    apb(1'b1, OFF_END32, 32'hcafe_f00d);
    apb(1'b1, REG_CTRL, 32'h2);
    run(32'h1); chk("busy32", 32'd72, n);
    rd(OFF_FCW, 32'h1234_037f, "fcw_fsw");
    rd(OFF_TAG, 32'h07ab_00e3, "tag_op");
    rd(OFF_INSTR, 32'h3333_4444, "ip");
    rd(OFF_INSTR_H, 32'h0000_0c0d, "csel");
    rd(OFF_DATA, 32'h7777_8888, "dp");
    rd(OFF_DATA_H, 32'h0000_1415, "dsel");
    rd(OFF_MCS, 32'h0000_1f80, "mcs");
    rd(OFF_MASK, 32'h0000_ffff, "mask");
    for (int i = 0; i < 8; i++) begin
      rd(OFF_STACK + 12'(i * 16), 32'h89ab_cdef, "st_lo");
      rd(OFF_STACK + 12'(i * 16 + 8), {16'h0, 16'hc000 + 16'(i)}, "st_hi");
      rd(OFF_STACK + 12'(i * 16 + 12), 32'h0, "st_rsv");
      rd(OFF_MEDIA + 12'(i * 16), 32'hd000_0000 + 32'(i), "media");
    end
    rd(OFF_END32, 32'hcafe_f00d, "above_end");
    $display("test store32 done");
    // Store, 64-bit format
    apb(1'b1, REG_CTRL, 32'h3);
    run(32'h1); chk("busy64", 32'd104, n);
    rd(OFF_INSTR, 32'h3333_4444, "ip64lo");
    rd(OFF_INSTR_H, 32'h1111_2222, "ip64hi");
    rd(OFF_DATA, 32'h7777_8888, "dp64lo");
    rd(OFF_DATA_H, 32'h5555_6666, "dp64hi");
    rd(OFF_END32, 32'hd000_0008, "media8");
    $display("test store64 done");
    // Store with media save disabled leaves media words alone
    apb(1'b1, OFF_MCS, 32'h0000_abcd);
    apb(1'b1, OFF_MEDIA, 32'h5a5a_5a5a);
    apb(1'b1, REG_CTRL, 32'h0);
    dpv <= 1'b0;
    run(32'h1); chk("busy_off", 32'd40, n);
    rd(OFF_MCS, 32'h0000_abcd, "mcs_kept");
    rd(OFF_MEDIA, 32'h5a5a_5a5a, "media_kept");
    rd(OFF_DATA, 32'h0, "dp_zero");
    rd(OFF_DATA_H, 32'h0, "dsel_zero");
    $display("test store_off done");
    // Software edits the image, then loads it back
    apb(1'b1, REG_CTRL, 32'h2);
    apb(1'b0, OFF_MASK, 32'h0);
    i_fpimg_sysmem.mem[7] = q;
    i_fpimg_sysmem.mem[0] = 32'h5678_0123;
    i_fpimg_sysmem.mem[1] = 32'h0abc_0081;
    i_fpimg_sysmem.mem[6] = i_fpimg_sysmem.mcs_clean(32'hffff_1f80, q);
    i_fpimg_sysmem.mem[40] = 32'h0bad_cafe;
    for (int w = 0; w < IMG_WORDS; w++)
      if (w == 0 || w == 1 || w == 6 || w == 40)
        apb(1'b1, 12'(w * 4), i_fpimg_sysmem.mem[w]);
    run(32'h2); chk("busy_load", 32'd72, n);
    chk("load_done", 32'h1, {31'h0, ld});
    chk("r_fcw", 32'h0000_0123, {16'h0, rs.fp_control_word});
    chk("r_tag", 32'h0000_3ffc, {16'h0, rs.tag});
    chk("r_op", 32'h0000_0abc, {16'h0, rs.opcode});
    chk("r_mcs", 32'h0000_1f80, rs.mcs);
    chk("r_media", 32'h0bad_cafe, rs.media[0][31:0]);
    chk("r_st2", 32'h0000_c002, {16'h0, rs.st[2][79:64]});
    $display("test load done");
    // Reserved media control bit refuses the load
    apb(1'b1, OFF_MCS, 32'h0001_0000);
    apb(1'b1, REG_CMD, 32'h2);
    n = 0;
    // The fault pulse stands only in the cycle after the access edge
    for (int k = 0; k < 8; k++) begin
      #1;
      if (gp_fault === 1'b1) begin n = 1; break; end
      @(posedge pclk);
    end
    chk("gp_fault", 32'h1, n);
    chk("no_load", 32'h0000_0123, {16'h0, rs.fp_control_word});
    apb(1'b0, REG_STATUS, 32'h0); chk("sticky", 32'h2, q & 32'h3);
    apb(1'b1, REG_STATUS, 32'h2);
    apb(1'b0, REG_STATUS, 32'h0); chk("cleared", 32'h0, q & 32'h3);
    apb(1'b0, 12'h20c, 32'h0); chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_q", 32'h0, q);
    $display("test fault done");
    report_and_stop();
  end
endmodule : fp_state_image_formatter_bench
`default_nettype wire
